/* File: verification/aisc_icu_model.sv */
/*
  model of the interrupt control unit: samples the audio request each edge.
  assumes the request is a registered active-high level on mclk.
*/
`timescale 1ns/1ps
module aisc_icu_model (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // request from the block, and its sampled copy
  input  wire logic audio_irq,
  output logic      irq_seen_r
);
  // latch the level as the unit would; one request line only
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_seen_r <= 1'b0;
    end else begin
      irq_seen_r <= audio_irq;
    end
  end
endmodule

/* File: verification/aisc_top_test.sv */
/*
  self-checking bench: table of enable/condition rows, then clears and reset.
  assumes a write shows in the read word and request within 4 edges.
*/
`timescale 1ns/1ps
module audio_interrupt_status_control_test;
  import aisc_pkg::*;
  typedef struct packed {logic [3:0] en; logic [4:0] cnt; logic [3:0] lvl; logic [2:0] f; logic [3:0] pend;} aisc_row_t;
  // rows: enables, fifo count, level, {underrun, almost empty, overrun}, pending
  localparam aisc_row_t ROWS [7] = '{'{4'h1, 5'h03, 4'h2, 3'h0, 4'h1}, '{4'h1, 5'h02, 4'h2, 3'h0, 4'h0},
    '{4'h0, 5'h1f, 4'h0, 3'h7, 4'h0}, '{4'h2, 5'h00, 4'h0, 3'h1, 4'h2}, '{4'h4, 5'h00, 4'h0, 3'h2, 4'h4},
    '{4'h8, 5'h00, 4'h0, 3'h4, 4'h8}, '{4'hf, 5'h10, 4'hf, 3'h7, 4'hf}};
  logic        mclk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, irq, seen; // clock, strobes, request
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;                    // register word
  logic [4:0]  cnt = 5'h00;                                          // receive fifo count
  logic [3:0]  lvl = 4'h0;                                           // warning level
  logic [2:0]  f = 3'h0;                                             // {underrun, almost empty, overrun}
  int          n_errors = 0, n_compared = 0;                         // counters
  always #20 mclk = ~mclk;
  aisc_top i_dut (.mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .rx_fifo_count(cnt), .rx_warning_level(lvl), .rx_overrun_flag(f[0]), .tx_almost_empty_flag(f[1]),
    .tx_underrun_flag(f[2]), .audio_irq(irq));
  aisc_icu_model i_icu (.mclk(mclk), .rst_n(rst_n), .audio_irq(irq), .irq_seen_r(seen));
  // drive conditions at an edge
  task automatic set_cond(input logic [4:0] c, input logic [3:0] l, input logic [2:0] x);
    @(posedge mclk);
    cnt <= c;
    lvl <= l;
    f <= x;
  endtask
  // one-cycle write, then let it settle
  task automatic wr(input logic [15:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    repeat (4) @(posedge mclk);
    #1;
  endtask
  // compare and count
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // verdict
  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    // table rows: clear all, then enable under set conditions
    foreach (ROWS[i]) begin
      set_cond(5'h00, 4'h0, 3'h0);
      wr(16'h0f00);
      set_cond(ROWS[i].cnt, ROWS[i].lvl, ROWS[i].f);
      wr({12'h000, ROWS[i].en});
      chk("word", {8'h00, ROWS[i].pend, ROWS[i].en}, reg_rdata);
      chk("irq", {15'h0, |(ROWS[i].pend & ROWS[i].en)}, {15'h0, irq});
      chk("icu", {15'h0, |(ROWS[i].pend & ROWS[i].en)}, {15'h0, seen});
      $display("row %0d done", i);
    end
    // pending stays; writes to pending, reserved and zero clears ignored
    set_cond(5'h00, 4'h0, 3'h0);
    wr(16'hf0ff);
    chk("no clear", 16'h00ff, reg_rdata);
    wr(16'h040f);
    chk("tx clear", 16'h00bf, reg_rdata);
    wr(16'h0b0f);
    chk("rest clear", 16'h000f, reg_rdata);
    chk("irq off", 16'h0000, {15'h0, irq});
    $display("clear test done");
    // reset in mid-run with sources pending
    set_cond(5'h1f, 4'h0, 3'h7);
    wr(16'h000f);
    @(posedge mclk);
    rst_n <= 1'b0;
    #1;
    chk("reset word", 16'h0000, reg_rdata);
    chk("reset irq", 16'h0000, {15'h0, irq});
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    // conditions still high, but enables came back low: nothing pends
    chk("after reset word", 16'h0000, reg_rdata);
    chk("after reset icu", 16'h0000, {15'h0, seen});
    // first write after release: receive error source alone
    wr(16'h0002);
    chk("first write word", 16'h0022, reg_rdata);
    chk("first write irq", 16'h0001, {15'h0, irq});
    $display("reset test done");
    tally_and_finish();
  end
endmodule

/* File: verilog/aisc_flag_bank.sv */
/*
  holds the four sticky pending flags of the audio interrupt sources.
  assumes clear strobes last one cycle and conditions are synchronous to mclk.
*/
`timescale 1ns/1ps
module aisc_flag_bank
  import aisc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // control side
  aisc_flag_if.bank fl
);
  import aisc_pkg::*;

  // whole state of the bank
  typedef struct packed {
    logic [3:0] pend;  // pending flags
  } aisc_bank_st_t;

  aisc_bank_st_t st_r;    // registered state
  aisc_bank_st_t st_nxt;  // next state

  // set wins over a clear arriving in the same cycle
  always_comb begin
    st_nxt      = st_r;
    st_nxt.pend = (st_r.pend & ~fl.clr) | (fl.cond & fl.en);
  end

  // state register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r.pend <= AISC_PEND_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign fl.pend = st_r.pend;

  // per-source checks
  for (genvar i = 0; i < AISC_SRC_N; i++) begin : g_chk
    AST_CLEAR_DROPS: assert property (@(posedge mclk) disable iff (!rst_n)
      fl.clr[i] && !(fl.cond[i] && fl.en[i]) |=> !fl.pend[i])
      else $error("pending flag survived its clear");
    AST_FLAG_HOLDS: assert property (@(posedge mclk) disable iff (!rst_n)
      fl.pend[i] && !fl.clr[i] |=> fl.pend[i])
      else $error("pending flag dropped without a clear");
    AST_GATED_OFF: assert property (@(posedge mclk) disable iff (!rst_n)
      !fl.pend[i] && !fl.en[i] |=> !fl.pend[i])
      else $error("pending flag set while its enable was low");
  end
endmodule

/* File: verilog/aisc_flag_if.sv */
/*
  carrier between the register logic and the pending-flag bank.
  assumes both ends run on mclk of the same block.
*/
`timescale 1ns/1ps
interface aisc_flag_if;
  logic [3:0] cond;  // raw source conditions
  logic [3:0] en;    // enable bits
  logic [3:0] clr;   // one-cycle clear strobes
  logic [3:0] pend;  // pending flags
  modport ctrl (output cond, output en, output clr, input pend);
  modport bank (input cond, input en, input clr, output pend);
endinterface

/* File: verilog/aisc_pkg.sv */
/*
  constants shared by the audio interrupt status and control block:
  field positions of the 16-bit status/control word, widths and reset values.
  assumes nothing of its surroundings; imported by the flag bank and the top module.
*/
package aisc_pkg;
  localparam int          AISC_DATA_W      = 16;     // width of the status/control word
  localparam int          AISC_SRC_N       = 4;      // rx, rx error, tx, tx error
  localparam int          AISC_EN_LSB      = 0;      // enable field, bits 3..0
  localparam int          AISC_PEND_LSB    = 4;      // pending field, bits 7..4
  localparam int          AISC_CLR_LSB     = 8;      // clear strobes, bits 11..8
  localparam int          AISC_SRC_RX      = 0;      // source index: receive
  localparam int          AISC_SRC_RXERR   = 1;      // source index: receive error
  localparam int          AISC_SRC_TX      = 2;      // source index: transmit
  localparam int          AISC_SRC_TXERR   = 3;      // source index: transmit error
  localparam int          AISC_FIFO_CNT_W  = 5;      // receive fifo entry count width
  localparam int          AISC_LEVEL_W     = 4;      // receive warning level width
  localparam logic [3:0]  AISC_EN_RST      = 4'h0;   // enables after reset
  localparam logic [3:0]  AISC_PEND_RST    = 4'h0;   // pending flags after reset
  localparam logic [15:0] AISC_WORD_RST    = 16'h0000; // read word after reset
endpackage

/* File: verilog/aisc_top.sv */
/*
  audio interrupt status and control word: enables, pending flags, clear
  strobes, and the single request to the interrupt control unit.
  assumes a synchronous cpu write strobe with data; read data is always
  presented, one cycle behind the state; condition inputs synchronous to mclk.
  the request to the interrupt control unit is a registered level and drops
  only once every enabled pending flag has been cleared or disabled.
  pending flags are levels that re-arm while their condition persists and their enable is set, so a
  clear written while both still hold is overridden: set wins.
  disabling a source hides its flag from the request but keeps the flag.
  the checks at the bottom of this file guard the word layout, the clears,
  the gating by the enables and the request as the flags and enables read.
*/
`timescale 1ns/1ps
module aisc_top
  import aisc_pkg::*;
(
  // clock and reset
  input  wire logic                       mclk,
  input  wire logic                       rst_n,
  // cpu access to the status/control word
  input  wire logic                       reg_wr,
  input  wire logic [AISC_DATA_W-1:0]     reg_wdata,
  output logic      [AISC_DATA_W-1:0]     reg_rdata,
  // conditions from the audio serial unit
  input  wire logic [AISC_FIFO_CNT_W-1:0] rx_fifo_count,
  input  wire logic [AISC_LEVEL_W-1:0]    rx_warning_level,
  input  wire logic                       rx_overrun_flag,
  input  wire logic                       tx_almost_empty_flag,
  input  wire logic                       tx_underrun_flag,
  // request to the interrupt control unit
  output logic                            audio_irq
);
  import aisc_pkg::*;

  // whole state of the register side
  typedef struct packed {
    logic [3:0]             en;    // enable bits
    logic                   irq;   // registered request
    logic [AISC_DATA_W-1:0] rdata; // registered read word
  } aisc_top_st_t;

  aisc_top_st_t st_r;    // registered state
  aisc_top_st_t st_nxt;  // next state
  logic         rx_cond; // receive fifo above warning level

  aisc_flag_if fl ();    // link to the flag bank

  // receive condition decode: strictly more entries than the warning level;
  // the level is zero-extended, so a level of zero fires on one entry
  function automatic logic above_level(
    input logic [AISC_FIFO_CNT_W-1:0] cnt, // entries in the receive fifo
    input logic [AISC_LEVEL_W-1:0]    lvl  // programmed warning level
  );
    return cnt > AISC_FIFO_CNT_W'(lvl);
  endfunction

  // receive condition: strictly more entries than the warning level
  assign rx_cond = above_level(rx_fifo_count, rx_warning_level);

  // source conditions in bit order of the word
  assign fl.cond = {tx_underrun_flag, tx_almost_empty_flag, rx_overrun_flag, rx_cond};
  assign fl.en   = st_r.en;
  // clear strobes exist only in the write cycle; zeros do nothing
  assign fl.clr  = reg_wr ? reg_wdata[AISC_CLR_LSB +: AISC_SRC_N] : 4'h0;

  aisc_flag_bank u_bank (
    .mclk  (mclk),
    .rst_n (rst_n),
    .fl    (fl.bank)
  );

  // next state: enables written, request and read word refreshed
  always_comb begin
    st_nxt = st_r;
    if (reg_wr) begin
      st_nxt.en = reg_wdata[AISC_EN_LSB +: AISC_SRC_N];
    end
    st_nxt.irq   = |(fl.pend & st_r.en);
    // clear strobes and reserved bits always read zero
    st_nxt.rdata = {8'h00, fl.pend, st_r.en};
  end

  // state register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r.en    <= AISC_EN_RST;
      st_r.irq   <= 1'b0;
      st_r.rdata <= AISC_WORD_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign audio_irq = st_r.irq;

  // enables keep their value between writes
  AST_EN_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    !reg_wr |=> st_r.en == $past(st_r.en))
    else $error("enable bits changed without a write");

  // enable field of the read word trails the enables by one edge
  AST_RDATA_EN: assert property (@(posedge mclk) disable iff (!rst_n)
    1'b1 |=> reg_rdata[3:0] == $past(st_r.en))
    else $error("enable field does not show the enables");

  // a write with all clear bits zero never drops a pending flag
  AST_ZERO_CLEARS_KEEP: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_wr && (reg_wdata[11:8] == 4'h0) |=> (fl.pend & $past(fl.pend)) == $past(fl.pend))
    else $error("zero clear bits dropped a pending flag");

  // receive clear drops the receive flag unless it re-arms at once
  AST_RX_CLEAR: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_wr && reg_wdata[8] && !(rx_cond && st_r.en[0]) |=> !fl.pend[0])
    else $error("receive pending survived its clear");

  // receive error clear drops the receive error flag
  AST_RXERR_CLEAR: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_wr && reg_wdata[9] && !(rx_overrun_flag && st_r.en[1]) |=> !fl.pend[1])
    else $error("receive error pending survived its clear");

  // transmit clear drops the transmit flag
  AST_TX_CLEAR: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_wr && reg_wdata[10] && !(tx_almost_empty_flag && st_r.en[2]) |=> !fl.pend[2])
    else $error("transmit pending survived its clear");

  // transmit error clear drops the transmit error flag
  AST_TXERR_CLEAR: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_wr && reg_wdata[11] && !(tx_underrun_flag && st_r.en[3]) |=> !fl.pend[3])
    else $error("transmit error pending survived its clear");

  // a write drops no flag whose clear bit was zero
  AST_CLEAR_ONLY_PAIR: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_wr |=> ($past(fl.pend) & ~$past(reg_wdata[11:8]) & ~fl.pend) == 4'h0)
    else $error("a clear dropped a flag it does not pair with");

  // receive flag stays down while its enable is low
  AST_RX_OFF: assert property (@(posedge mclk) disable iff (!rst_n)
    !st_r.en[0] && !fl.pend[0] |=> !fl.pend[0])
    else $error("receive pending set while disabled");

  // receive error flag stays down while its enable is low
  AST_RXERR_OFF: assert property (@(posedge mclk) disable iff (!rst_n)
    !st_r.en[1] && !fl.pend[1] |=> !fl.pend[1])
    else $error("receive error pending set while disabled");

  // transmit flag stays down while its enable is low
  AST_TX_OFF: assert property (@(posedge mclk) disable iff (!rst_n)
    !st_r.en[2] && !fl.pend[2] |=> !fl.pend[2])
    else $error("transmit pending set while disabled");

  // transmit error flag stays down while its enable is low
  AST_TXERR_OFF: assert property (@(posedge mclk) disable iff (!rst_n)
    !st_r.en[3] && !fl.pend[3] |=> !fl.pend[3])
    else $error("transmit error pending set while disabled");

  // no enable, no request
  AST_IRQ_OFF_ALL: assert property (@(posedge mclk) disable iff (!rst_n)
    st_r.en == 4'h0 |=> !audio_irq)
    else $error("request raised with every enable low");

  // reserved bits read zero
  AST_RESERVED_ZERO: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_rdata[15:12] == 4'h0)
    else $error("reserved bits read nonzero");

  // clear strobes read zero
  AST_CLEAR_READS_ZERO: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_rdata[11:8] == 4'h0)
    else $error("clear bits read nonzero");

  // receive flag does not arm at or below the warning level
  AST_RXCOND_LEVEL: assert property (@(posedge mclk) disable iff (!rst_n)
    !above_level(rx_fifo_count, rx_warning_level) && !fl.pend[0] |=> !fl.pend[0])
    else $error("receive pending set at or below warning level");

  // request agrees with the read word, both one edge behind the state
  AST_IRQ_MATCHES_READ: assert property (@(posedge mclk) disable iff (!rst_n)
    audio_irq == |(reg_rdata[7:4] & reg_rdata[3:0]))
    else $error("request disagrees with the read word");

  // a rising request has an enabled flag behind it
  AST_IRQ_RISE_CAUSE: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(audio_irq) |-> $past(|(fl.pend & st_r.en)))
    else $error("request rose with no enabled flag");

  // a falling request follows the last enabled flag going away
  AST_IRQ_FALL_CAUSE: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(audio_irq) |-> $past(!(|(fl.pend & st_r.en))))
    else $error("request fell while an enabled flag pended");

  AST_EN_WRITE: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_wr |=> st_r.en == $past(reg_wdata[3:0]))
    else $error("enable bits did not take the written value");
  AST_UPPER_ZERO: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_rdata[15:8] == 8'h00)
    else $error("clear or reserved bits read nonzero");
  AST_RX_RAISE: assert property (@(posedge mclk) disable iff (!rst_n)
    st_r.en[0] && above_level(rx_fifo_count, rx_warning_level) |=> fl.pend[0])
    else $error("receive pending not raised above warning level");
  AST_RXERR_RAISE: assert property (@(posedge mclk) disable iff (!rst_n)
    st_r.en[1] && rx_overrun_flag |=> fl.pend[1])
    else $error("receive error pending not raised on overrun");
  AST_TX_RAISE: assert property (@(posedge mclk) disable iff (!rst_n)
    st_r.en[2] && tx_almost_empty_flag |=> fl.pend[2])
    else $error("transmit pending not raised on almost empty");
  AST_TXERR_RAISE: assert property (@(posedge mclk) disable iff (!rst_n)
    st_r.en[3] && tx_underrun_flag |=> fl.pend[3])
    else $error("transmit error pending not raised on underrun");
  AST_IRQ_FOLLOWS: assert property (@(posedge mclk) disable iff (!rst_n)
    (|(fl.pend & st_r.en)) |=> audio_irq)
    else $error("request missing while an enabled flag pends");
  AST_IRQ_QUIET: assert property (@(posedge mclk) disable iff (!rst_n)
    !(|(fl.pend & st_r.en)) |=> !audio_irq)
    else $error("request raised with no enabled flag pending");
  AST_READ_PEND: assert property (@(posedge mclk) disable iff (!rst_n)
    1'b1 |=> reg_rdata[7:4] == $past(fl.pend))
    else $error("pending field does not show the flags");
endmodule
